/* File: include/cst_params.svh */
// Purpose: constants for the clock source, trim and output block
// Assumes: 10 MHz block clock, AHB-Lite register access
// Notes:   counts above 4096 cycles reach the top as parameters
//
// Summary of operation
// - Reset loads factory trim byte into trim
// - Trim zero slowest, 0xFF fastest oscillator
// - Trim bit 7 picks low or high range
// - Lower seven bits tune within chosen range
// - Memory timing always uses calibrated RC trim
// - Source code 00 selects external clock pin
// - External clock start-up delays per code
// - PLL 64 MHz, divided by four as system
// - PLL start-up delays per code
// - Source code 11 selects 128 kHz oscillator
// - 128 kHz start-up delays per code
// - Clock out setting drives clock onto pin
// - No clock on pin during reset
// - Pin carries prescaled system clock; code toggles a flop, giving half the prescaled rate
// - Calibrated RC runs nominal 8 MHz, no parts
`ifndef CST_PARAMS_SVH
`define CST_PARAMS_SVH

// Register map, byte addresses
`define CST_ADDR_W 8
`define CST_DATA_W 32
`define CST_OFS_CFG 8'h00
`define CST_OFS_PRESC 8'h04
`define CST_IDX_TRIM 6'h31
`define CST_OFS_TRIM {`CST_IDX_TRIM, 2'b00}

// Fields and reset values
`define CST_TRIM_RANGE_BIT 7
`define CST_PRESC_RESET 4'h0
`define CST_PRESC_MAX 4'h8
`define CST_DIV_W 9

// Source and start-up codes
`define CST_SEL_EXT 4'h0
`define CST_SEL_PLL 4'h1
`define CST_SEL_LP128 4'h3
`define CST_SUT_RSVD 2'h3

// Start-up counts in clock cycles
`define CST_CK_PD 6
`define CST_CK_RST 14
`define CST_CK_1K 1024
`define CST_CK_16K 16384
`define CST_CNT_W 24

// Times and their cycle counts, rounded up
`define CST_CLK_KHZ 10000
`define CST_T4MS_US 4000
`define CST_T8MS_US 8000
`define CST_T64MS_US 64000
`define CST_T68MS_US 68000
`define CST_US2CYC(us) ((((us) * `CST_CLK_KHZ) + 999) / 1000)

`endif

/* File: include/cst_pkg.sv */
// Purpose: shared types of the clock source block
// Assumes: nothing beyond the constants header
// Notes:   state codes left to the tools
`default_nettype none

package cst_pkg;

    // Start-up sequencer states
    typedef enum {
        ST_BOOT,
        ST_WAIT,
        ST_RUN,
        ST_SLEEP
    } cst_state_type;

    // Decoded system clock source
    typedef enum logic [1:0] {
        SRC_EXT,
        SRC_PLL,
        SRC_LP128,
        SRC_OTHER
    } cst_source_type;

endpackage

`default_nettype wire

/* File: rtl/cst_startup_timer.sv */
// Purpose: down counter timing one start-up delay
// Assumes: start is a one-cycle pulse from the same clock
// Notes:   busy falls load value cycles after start
`default_nettype none

module cst_startup_timer #(
    parameter int CNT_W = 24
) (
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             start,
    input  wire logic [CNT_W-1:0] loadValue,
    output logic                  busy
);

    logic [CNT_W-1:0] count_r;

    // Load on start, then count down to zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count_r <= '0;
        end else if (start) begin
            count_r <= loadValue;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign busy = (count_r != '0);

endmodule

`default_nettype wire

/* File: rtl/cst_clock_control.sv */
// Purpose: trim register, source decode, start-up and clock out
// Assumes: setting pins quasi static, sampled while rst_n low
// Notes:   pin clock is a flop toggle, half the prescaled rate
//
// The AHB-Lite slave port was decided locally.
`include "cst_params.svh"
`default_nettype none

module cst_clock_control #(
    parameter int T4MS_CYC  = `CST_US2CYC(`CST_T4MS_US),
    parameter int T8MS_CYC  = `CST_US2CYC(`CST_T8MS_US),
    parameter int T64MS_CYC = `CST_US2CYC(`CST_T64MS_US),
    parameter int T68MS_CYC = `CST_US2CYC(`CST_T68MS_US),
    parameter int CK16K_CYC = `CST_CK_16K,
    parameter int CW        = `CST_CNT_W
) (
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   hsel,
    input  wire logic [`CST_ADDR_W-1:0] haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic                   hready,
    input  wire logic [`CST_DATA_W-1:0] hwdata,
    output logic [`CST_DATA_W-1:0]      hrdata,
    output logic                        hreadyout,
    output logic                        hresp,
    input  wire logic [3:0]             clockSourceSelect,
    input  wire logic [1:0]             startupTimeSelect,
    input  wire logic                   clockOutEnableSetting,
    input  wire logic [7:0]             factoryTrim,
    input  wire logic                   sleepRequest,
    output logic                        trimRangeBit,
    output logic [6:0]                  trimFineField,
    output logic [7:0]                  nvmTimingTrim,
    output logic                        rcOscEnable,
    output logic                        pllEnable,
    output logic                        pllSystemClock,
    output logic                        externalClockInEn,
    output cst_pkg::cst_source_type     sysClockSource,
    output logic                        startupCodeBad,
    output logic                        coreRun,
    output logic                        clockOutPin,
    output logic                        clockOutOe,
    output logic                        gpioOverride
);

    localparam int SW = 16;

    logic [SW-1:0]           syncA_r;
    logic [SW-1:0]           syncB_r;
    logic [3:0]              cfgSel_r;
    logic [1:0]              cfgSut_r;
    logic                    cfgClkOut_r;
    cst_pkg::cst_source_type src;
    logic [7:0]              trim_r;
    logic [3:0]              presc_r;
    logic                    wrPend_r;
    logic [`CST_ADDR_W-1:0]  addrPh_r;
    logic [`CST_DATA_W-1:0]  readMux;
    cst_pkg::cst_state_type  state_r;
    cst_pkg::cst_state_type  stateNxt;
    logic                    timerStart;
    logic                    timerBusy;
    logic [CW-1:0]           delayNxt;
    logic [CW-1:0]           lastLoad_r;
    logic [CW-1:0]           waitCnt_r;
    logic [`CST_DIV_W-1:0]   divCnt_r;
    logic [`CST_DIV_W-1:0]   divLimit;
    logic [`CST_DIV_W-1:0]   gapCnt_r;
    logic                    sleepSync;
    logic                    prescWrite;

    // Two flops on every pin; first stage read only by the second
    always_ff @(posedge clock) begin
        syncA_r <= {clockSourceSelect, startupTimeSelect,
                    clockOutEnableSetting, factoryTrim, sleepRequest};
        syncB_r <= syncA_r;
    end

    assign sleepSync = syncB_r[0];

    // Settings caught while reset is held, frozen afterwards
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cfgSel_r    <= syncB_r[15:12];
            cfgSut_r    <= syncB_r[11:10];
            cfgClkOut_r <= syncB_r[9];
        end
    end

    // Decode of the source selection
    always_comb begin
        unique case (cfgSel_r)
            `CST_SEL_EXT:   src = cst_pkg::SRC_EXT;
            `CST_SEL_PLL:   src = cst_pkg::SRC_PLL;
            `CST_SEL_LP128: src = cst_pkg::SRC_LP128;
            default:        src = cst_pkg::SRC_OTHER;
        endcase
    end

    // Start-up delay for the captured source and code
    function automatic logic [CW-1:0] delayFor(
        input cst_pkg::cst_source_type s,
        input logic [1:0]              sut,
        input logic                    fromReset
    );
        logic [CW-1:0] ck;
        logic [CW-1:0] ms;
        ck = CW'(`CST_CK_RST);
        ms = '0;
        if (s == cst_pkg::SRC_PLL) begin
            // Reset column uses 1K for code 11, power-down 16K
            if (sut == 2'h1 || (!fromReset && sut == 2'h3)) begin
                ck = CW'(`CST_CK_RST + CK16K_CYC);
            end else begin
                ck = CW'(`CST_CK_RST + `CST_CK_1K);
            end
            if (fromReset) begin
                ms = sut[1] ? CW'(T68MS_CYC) : CW'(T8MS_CYC);
            end else begin
                ms = sut[1] ? CW'(T64MS_CYC) : CW'(T4MS_CYC);
            end
        end else if (!fromReset) begin
            ck = CW'(`CST_CK_PD);
        end else begin
            // Reserved code falls back to the longest delay
            unique case (sut)
                2'h0: ms = '0;
                2'h1: ms = CW'(T4MS_CYC);
                2'h2: ms = CW'(T64MS_CYC);
                2'h3: ms = CW'(T64MS_CYC);
            endcase
        end
        return ck + ms;
    endfunction

    assign delayNxt = delayFor(src, cfgSut_r, state_r == cst_pkg::ST_BOOT);

    // Sequencer: boot, wait out delay, run, power-down
    always_comb begin
        stateNxt = state_r;
        unique case (state_r)
            cst_pkg::ST_BOOT:  stateNxt = cst_pkg::ST_WAIT;
            cst_pkg::ST_WAIT: begin
                if (!timerBusy) begin
                    stateNxt = cst_pkg::ST_RUN;
                end
            end
            cst_pkg::ST_RUN: begin
                if (sleepSync) begin
                    stateNxt = cst_pkg::ST_SLEEP;
                end
            end
            cst_pkg::ST_SLEEP: begin
                if (!sleepSync) begin
                    stateNxt = cst_pkg::ST_WAIT;
                end
            end
        endcase
    end

    assign timerStart = (state_r != cst_pkg::ST_WAIT)
                        && (stateNxt == cst_pkg::ST_WAIT);

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state_r <= cst_pkg::ST_BOOT;
        end else begin
            state_r <= stateNxt;
        end
    end

    cst_startup_timer #(
        .CNT_W     (CW)
    ) u_timer (
        .clock     (clock),
        .rst_n     (rst_n),
        .start     (timerStart),
        .loadValue (delayNxt),
        .busy      (timerBusy)
    );

    // Core held idle until the delay has run out
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            coreRun <= 1'b0;
        end else begin
            coreRun <= (stateNxt == cst_pkg::ST_RUN);
        end
    end

    // Trim loads from the factory byte during reset
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trim_r <= syncB_r[8:1];
        end else if (wrPend_r && addrPh_r == `CST_OFS_TRIM) begin
            trim_r <= hwdata[7:0];
        end
    end

    // Oscillator controls follow the trim register
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            trimRangeBit  <= 1'b0;
            trimFineField <= 7'h00;
            nvmTimingTrim <= 8'h00;
            rcOscEnable   <= 1'b0;
        end else begin
            trimRangeBit  <= trim_r[`CST_TRIM_RANGE_BIT];
            trimFineField <= trim_r[6:0];
            nvmTimingTrim <= trim_r;
            rcOscEnable   <= 1'b1;
        end
    end

    // Source steering; the PLL is kept enabled for every source
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            pllEnable         <= 1'b0;
            pllSystemClock    <= 1'b0;
            externalClockInEn <= 1'b0;
            sysClockSource    <= cst_pkg::SRC_OTHER;
            startupCodeBad    <= 1'b0;
        end else begin
            pllEnable         <= 1'b1;
            pllSystemClock    <= (src == cst_pkg::SRC_PLL);
            externalClockInEn <= (src == cst_pkg::SRC_EXT);
            sysClockSource    <= src;
            startupCodeBad    <= (src != cst_pkg::SRC_PLL)
                                 && (cfgSut_r == `CST_SUT_RSVD);
        end
    end

    // Prescaler select; reserved codes leave the old value
    assign prescWrite = wrPend_r && addrPh_r == `CST_OFS_PRESC
                        && hwdata[3:0] <= `CST_PRESC_MAX;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            presc_r <= `CST_PRESC_RESET;
        end else if (prescWrite) begin
            presc_r <= hwdata[3:0];
        end
    end

    assign divLimit = (`CST_DIV_W'(1) << presc_r) - 1'b1;

    // Pin toggles once per prescaled clock; quiet outside run
    always_ff @(posedge clock) begin
        if (!rst_n || stateNxt != cst_pkg::ST_RUN || prescWrite) begin
            divCnt_r    <= '0;
            clockOutPin <= 1'b0;
        end else if (divCnt_r == divLimit) begin
            divCnt_r    <= '0;
            clockOutPin <= ~clockOutPin;
        end else begin
            divCnt_r <= divCnt_r + 1'b1;
        end
    end

    // Pin ownership taken from the clock-out setting
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            clockOutOe   <= 1'b0;
            gpioOverride <= 1'b0;
        end else begin
            clockOutOe   <= cfgClkOut_r && stateNxt == cst_pkg::ST_RUN;
            gpioOverride <= cfgClkOut_r;
        end
    end

    // AHB address phase; zero wait states, so hready is ours
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            addrPh_r <= '0;
        end else if (hready) begin
            wrPend_r <= hsel && htrans[1] && hwrite;
            addrPh_r <= haddr;
        end
    end

    // Read word; unmapped addresses read zero
    always_comb begin
        readMux = '0;
        unique case (haddr)
            `CST_OFS_CFG: readMux = {21'h0, coreRun, sysClockSource,
                                     startupCodeBad, cfgClkOut_r,
                                     cfgSut_r, cfgSel_r};
            `CST_OFS_PRESC: readMux = {28'h0, presc_r};
            `CST_OFS_TRIM: readMux = {24'h0, trim_r};
            default: readMux = '0;
        endcase
    end

    // Read data stands for the data phase only
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            hrdata    <= '0;
            hreadyout <= 1'b0;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= readMux;
            end else begin
                hrdata <= '0;
            end
        end
    end

    // Helpers watched by the checks below
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            waitCnt_r  <= '0;
            lastLoad_r <= '0;
        end else if (timerStart) begin
            waitCnt_r  <= CW'(1);
            lastLoad_r <= delayNxt;
        end else if (stateNxt == cst_pkg::ST_WAIT) begin
            waitCnt_r <= waitCnt_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n || !coreRun || $changed(clockOutPin)
            || $changed(presc_r)) begin
            gapCnt_r <= '0;
        end else begin
            gapCnt_r <= gapCnt_r + 1'b1;
        end
    end

    default clocking cb @(posedge clock);
    endclocking

    default disable iff (!rst_n);

    property p_trimLoad;
        $rose(rst_n) |-> trim_r == $past(syncB_r[8:1]);
    endproperty
    a_trimLoad: assert property (p_trimLoad)
        else $error("trim not loaded from factory byte");

    property p_range;
        (wrPend_r && addrPh_r == `CST_OFS_TRIM)
            |-> ##2 trimRangeBit == $past(hwdata[7], 2);
    endproperty
    a_range: assert property (p_range)
        else $error("range bit does not follow trim write");

    property p_fine;
        (wrPend_r && addrPh_r == `CST_OFS_TRIM)
            |-> ##2 trimFineField == $past(hwdata[6:0], 2);
    endproperty
    a_fine: assert property (p_fine)
        else $error("fine field does not follow trim write");

    property p_nvmTrim;
        $past(rst_n) |-> nvmTimingTrim == $past(trim_r);
    endproperty
    a_nvmTrim: assert property (p_nvmTrim)
        else $error("memory timing trim differs from trim");

    property p_extSel;
        (cfgSel_r == `CST_SEL_EXT) |=> externalClockInEn
            && sysClockSource == cst_pkg::SRC_EXT;
    endproperty
    a_extSel: assert property (p_extSel)
        else $error("external clock not selected");

    property p_pllSel;
        (cfgSel_r == `CST_SEL_PLL) |=> pllSystemClock && pllEnable;
    endproperty
    a_pllSel: assert property (p_pllSel)
        else $error("PLL system clock not selected");

    property p_pllReset;
        (state_r == cst_pkg::ST_BOOT && src == cst_pkg::SRC_PLL
            && cfgSut_r == 2'h1)
            |=> lastLoad_r == CW'(`CST_CK_RST + CK16K_CYC + T8MS_CYC);
    endproperty
    a_pllReset: assert property (p_pllReset)
        else $error("PLL reset delay wrong");

    property p_lpSel;
        (cfgSel_r == `CST_SEL_LP128) |=>
            sysClockSource == cst_pkg::SRC_LP128 && !pllSystemClock;
    endproperty
    a_lpSel: assert property (p_lpSel)
        else $error("128 kHz source not selected");

    property p_wake;
        (state_r == cst_pkg::ST_SLEEP && timerStart
            && src != cst_pkg::SRC_PLL) |=> lastLoad_r == CW'(`CST_CK_PD);
    endproperty
    a_wake: assert property (p_wake)
        else $error("power-down wake delay wrong");

    property p_idle;
        $rose(coreRun) |-> waitCnt_r == lastLoad_r + 1'b1;
    endproperty
    a_idle: assert property (p_idle)
        else $error("core released before delay elapsed");

    property p_pinOwn;
        clockOutOe == (coreRun && gpioOverride);
    endproperty
    a_pinOwn: assert property (p_pinOwn)
        else $error("clock driven outside run or setting");

    property p_pinRate;
        (coreRun && $past(coreRun) && $changed(clockOutPin)
            && $stable(presc_r)) |-> gapCnt_r == divLimit;
    endproperty
    a_pinRate: assert property (p_pinRate)
        else $error("clock out period not prescaled");

    property p_cfgHeld;
        $past(rst_n) |-> $stable(cfgSel_r) && $stable(cfgSut_r)
            && $stable(cfgClkOut_r);
    endproperty
    a_cfgHeld: assert property (p_cfgHeld)
        else $error("settings changed while running");

endmodule

`default_nettype wire

/* File: tb/cst_nvm_model.sv */
// Purpose: non-volatile setting store on the far side of the block
// Assumes: want packs {source 4, start-up 2, clock out 1, trim 8}
// Notes:   copies each edge, so pins settle well inside a reset
`default_nettype none

module cst_nvm_model (
    input  wire logic        clock,
    input  wire logic [14:0] want,
    output logic      [14:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Large trim jumps only come with a reset
    // Run-time trim steps stay within 0x20
    // No store write is modelled, so the write speed cap is moot
    always_ff @(posedge clock) pins <= want;
endmodule

`default_nettype wire

/* File: tb/tb_clock_source_trim_and_output.sv */
// Purpose: self-checking bench for the clock source control block
// Assumes: long delays shortened by parameters, 10 MHz clock
// Notes:   outputs sampled just after an edge show pre-edge values
`include "cst_params.svh"
`default_nettype none

module tb_clock_source_trim_and_output;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T4 = 40;
    localparam int T8 = 80;
    localparam int T64 = 640;
    localparam int T68 = 680;
    localparam int K16 = 64;
    logic        clock, rst_n, hsel, hwrite, sleepRequest, hreadyout, hresp;
    logic [7:0]  haddr, nvmTimingTrim, t;
    logic [1:0]  htrans, u, src;
    logic [2:0]  hsize;
    logic [3:0]  s;
    logic [31:0] hwdata, hrdata, v;
    logic [14:0] want, pins;
    logic [6:0]  trimFineField;
    logic        trimRangeBit, rcOscEnable, pllEnable, pllSystemClock, externalClockInEn;
    logic        startupCodeBad, coreRun, clockOutPin, clockOutOe, gpioOverride;
    cst_pkg::cst_source_type sysClockSource;
    logic [7:0]  steps [3] = '{8'h7f, 8'h80, 8'h9f};
    int          presc [4] = '{0, 1, 3, 8};
    int          n_errors = 0;
    int          n_compared = 0;
    int          n;

    cst_clock_control #(.T4MS_CYC(T4), .T8MS_CYC(T8), .T64MS_CYC(T64), .T68MS_CYC(T68),
        .CK16K_CYC(K16)) dut (
        .clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .clockSourceSelect(pins[14:11]), .startupTimeSelect(pins[10:9]),
        .clockOutEnableSetting(pins[8]), .factoryTrim(pins[7:0]),
        .sleepRequest(sleepRequest), .trimRangeBit(trimRangeBit),
        .trimFineField(trimFineField), .nvmTimingTrim(nvmTimingTrim),
        .rcOscEnable(rcOscEnable), .pllEnable(pllEnable), .pllSystemClock(pllSystemClock),
        .externalClockInEn(externalClockInEn), .sysClockSource(sysClockSource),
        .startupCodeBad(startupCodeBad), .coreRun(coreRun), .clockOutPin(clockOutPin),
        .clockOutOe(clockOutOe), .gpioOverride(gpioOverride));

    cst_nvm_model nvm (.clock(clock), .want(want), .pins(pins));

    // Free running block clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %0t ns: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        $display("compared %0d, mismatched %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task automatic stuck;
        n_errors++;
        $display("[ERR] %0t ns: wait ran out", $time);
        conclude;
    endtask

    // Counts edges until coreRun shows lvl
    task automatic waitCore(input logic lvl, input int lim);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (coreRun !== lvl && n < lim);
        if (coreRun !== lvl) stuck;
    endtask

    task automatic waitReady;
        int k;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (hreadyout !== 1'b1 && k < 20);
        if (hreadyout !== 1'b1) stuck;
    endtask

    // One single word transfer; read data lands in v
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        waitReady;
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        waitReady;
        v = hrdata;
        chk(hresp, 1'b0);
    endtask

    // Edges between two changes of the clock out pin
    task automatic pinGap;
        logic last;
        last = clockOutPin;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (clockOutPin === last && n < 600);
        if (clockOutPin === last) stuck;
    endtask

    function automatic int rstD(input logic [3:0] sl, input logic [1:0] su);
        if (sl == 4'h1) return 14 + (su == 2'h1 ? K16 : 1024) + (su[1] ? T68 : T8);
        return 14 + (su == 2'h0 ? 0 : (su == 2'h1 ? T4 : T64));
    endfunction

    function automatic int wakeD(input logic [3:0] sl, input logic [1:0] su);
        if (sl == 4'h1) return 14 + (su[0] ? K16 : 1024) + (su[1] ? T64 : T4);
        return 6;
    endfunction

    // Reset with new settings, then time the start-up delay
    task automatic doReset(input logic [3:0] sl, input logic [1:0] su, input logic o,
        input logic [7:0] tr);
        @(posedge clock);
        rst_n <= 1'b0;
        want  <= {sl, su, o, tr};
        repeat (8) @(posedge clock);
        chk(clockOutPin, 1'b0);
        chk(clockOutOe, 1'b0);
        chk(hreadyout, 1'b0);
        rst_n <= 1'b1;
        waitCore(1'b1, 4000);
        chk(n, rstD(sl, su) + 3);
        chk({trimRangeBit, trimFineField}, tr);
        chk(nvmTimingTrim, tr);
    endtask

    // Main sequence
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        sleepRequest = 1'b0;
        want = 15'h0000;
        // Three sources, every start-up code, reset then power-down wake
        for (int i = 0; i < 12; i++) begin
            s = (i < 4) ? 4'h0 : ((i < 8) ? 4'h1 : 4'h3);
            u = i[1:0];
            src = (i < 4) ? 2'h0 : ((i < 8) ? 2'h1 : 2'h2);
            t = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : 8'h5a);
            doReset(s, u, u[0], t);
            chk(sysClockSource, src);
            chk(externalClockInEn, s == 4'h0);
            chk(pllSystemClock, s == 4'h1);
            chk(pllEnable, 1'b1);
            chk(rcOscEnable, 1'b1);
            chk(startupCodeBad, s != 4'h1 && u == 2'h3);
            chk(gpioOverride, u[0]);
            chk(clockOutOe, u[0]);
            ahb(1'b0, `CST_OFS_CFG, 32'h0);
            chk(v, {21'h0, 1'b1, src, s != 4'h1 && u == 2'h3, u[0], u, s});
            sleepRequest <= 1'b1;
            waitCore(1'b0, 20);
            chk(n, 4);
            sleepRequest <= 1'b0;
            waitCore(1'b1, 2000);
            chk(n, wakeD(s, u) + 5);
            $display("source %0d start-up %0d done", s, u);
        end
        // Trim steps, unmapped place, frozen settings, clock out rate
        doReset(4'h1, 2'h0, 1'b1, 8'h70);
        chk(clockOutOe, 1'b1);
        for (int j = 0; j < 3; j++) begin
            ahb(1'b1, `CST_OFS_TRIM, {24'h0, steps[j]});
            repeat (2) @(posedge clock);
            chk({trimRangeBit, trimFineField}, steps[j]);
            chk(nvmTimingTrim, steps[j]);
            ahb(1'b0, `CST_OFS_TRIM, 32'h0);
            chk(v, steps[j]);
        end
        ahb(1'b1, 8'h08, 32'h33);
        ahb(1'b0, 8'h08, 32'h0);
        chk(v, 32'h0);
        ahb(1'b0, `CST_OFS_TRIM, 32'h0);
        chk(v, 32'h9f);
        $display("trim test done");
        want <= {4'h0, 2'h2, 1'b0, 8'h11};
        repeat (6) @(posedge clock);
        chk(sysClockSource, 2'h1);
        chk(gpioOverride, 1'b1);
        chk(nvmTimingTrim, 8'h9f);
        for (int j = 0; j < 4; j++) begin
            ahb(1'b1, `CST_OFS_PRESC, presc[j]);
            repeat (3) pinGap;
            chk(n, 1 << presc[j]);
        end
        ahb(1'b1, `CST_OFS_PRESC, 32'h9);
        ahb(1'b0, `CST_OFS_PRESC, 32'h0);
        chk(v, 32'h8);
        $display("clock out test done");
        doReset(4'h0, 2'h0, 1'b1, 8'h70);
        $display("final reset test done");
        // Unlisted source code falls back to the plain table
        doReset(4'h2, 2'h1, 1'b0, 8'h3c);
        chk(sysClockSource, 2'h3);
        chk(externalClockInEn | pllSystemClock, 1'b0);
        chk(clockOutOe, 1'b0);
        $display("other source test done");
        conclude;
    end
endmodule

`default_nettype wire
